// file: src/four_pin_gpio_bank.sv
// module: four pin gpio bank behind one 8-bit control register
// ---------------------------------------------------------------
// Functional notes
// - direction bit 0 makes pin an input
// - direction bit 1 makes pin a driven output
// - input pin read returns sampled pin level
// - write never disturbs an input pin
// - output pin drives last written data bit
// - both nibbles reset to zero, read/write
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module four_pin_gpio_bank
   import gpio_bank_pkg::*;
#(
   parameter int WIDTH = PIN_COUNT
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // register port
   input wire logic [14:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_ack,
   // pins
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [WIDTH-1:0] dir;   // pin3..0_direction
      logic [WIDTH-1:0] level; // pin3..0_level storage
      logic [7:0] rdata;       // read data
      logic ack;               // access answered
   } bank_type;

   bank_type b_r;   // registered state
   bank_type b_nxt; // next state
   logic hit;       // address decode
   logic [WIDTH-1:0] read_level; // per-pin data bit view

   gpio_pin_if #(.WIDTH(WIDTH)) pins ();

   // decode of the single control register
   assign hit = (reg_addr == CONTROL_OFFSET);

   // read view: inputs show pin, outputs show stored bit
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         read_level[i] = b_r.dir[i] ? b_r.level[i]
                                    : pins.sampled[i];
      end
   end

   // next state: writes store both nibbles, reads return view
   always_comb begin
      b_nxt = b_r;
      b_nxt.ack = (reg_wr | reg_rd) & hit;
      if (reg_wr && hit) begin
         b_nxt.dir = reg_wdata[DIR_LSB +: WIDTH];
         // data bit stored even for inputs; it reaches the pad only
         // once the pin is an output
         b_nxt.level = reg_wdata[LEVEL_LSB +: WIDTH];
      end
      if (reg_rd && hit) begin
         b_nxt.rdata = {b_r.dir, read_level};
      end else if (reg_rd) begin
         b_nxt.rdata = 8'h00; // unmapped reads return zero
      end
   end

   // registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         b_r.dir <= DIR_RESET;
         b_r.level <= LEVEL_RESET;
         b_r.rdata <= 8'h00;
         b_r.ack <= 1'b0;
      end else begin
         b_r <= b_nxt;
      end
   end

   assign pins.dir = b_r.dir;
   assign pins.level = b_r.level;

   // pin synchronisers and drivers
   gpio_pin_stage #(.WIDTH(WIDTH)) u_stage (
      .clk(clk),
      .sys_rst(sys_rst),
      .pins(pins.stage),
      .pad_in(pin_in),
      .pad_out(pin_out),
      .pad_oe(pin_oe)
   );

   assign reg_rdata = b_r.rdata;
   assign reg_ack = b_r.ack;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   sequence s_dir_write(int n);
      reg_wr && hit && reg_wdata[DIR_LSB + n];
   endsequence

   property p_input_no_drive;
      @(posedge clk) disable iff (sys_rst)
      (b_r.dir == 4'h0) |=> (pin_oe == 4'h0);
   endproperty
   a_input_no_drive: assert property (p_input_no_drive)
      else $error("input pin driven");

   property p_out_enable;
      @(posedge clk) disable iff (sys_rst)
      s_dir_write(0) |=> ##1 pin_oe[0];
   endproperty
   a_out_enable: assert property (p_out_enable)
      else $error("pin0 not driven after direction write");

   property p_read_input;
      @(posedge clk) disable iff (sys_rst)
      (reg_rd && hit && !b_r.dir[1]) |=>
         reg_rdata[1] == $past(pins.sampled[1]);
   endproperty
   a_read_input: assert property (p_read_input)
      else $error("input read mismatch");

   property p_input_stable;
      @(posedge clk) disable iff (sys_rst)
      (reg_wr && hit && !reg_wdata[DIR_LSB] && !b_r.dir[0]) |=>
         ##1 !pin_oe[0];
   endproperty
   a_input_stable: assert property (p_input_stable)
      else $error("write disturbed input pin");

   property p_out_value;
      @(posedge clk) disable iff (sys_rst)
      (reg_wr && hit) |=> ##1 (pin_out == $past(reg_wdata[3:0], 2));
   endproperty
   a_out_value: assert property (p_out_value)
      else $error("output not written value");

   property p_reset_zero;
      @(posedge clk) sys_rst |=> (b_r.dir == 4'h0 && b_r.level == 4'h0);
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("reset value not zero");

   property p_turn_on;
      @(posedge clk) disable iff (sys_rst)
      $rose(b_r.dir[2]) |=> (pin_oe[2] && pin_out[2] == $past(b_r.level[2]));
   endproperty
   a_turn_on: assert property (p_turn_on)
      else $error("stored value not driven at turn on");

   // an access that hits the register
   sequence s_mapped_access;
      (reg_wr || reg_rd) && hit;
   endsequence

   // back-to-back accesses keep ack high, so only the next edge is checked
   property p_ack;
      @(posedge clk) disable iff (sys_rst)
      s_mapped_access |=> reg_ack;
   endproperty
   a_ack: assert property (p_ack)
      else $error("access not answered");

   // idle cycles and unmapped accesses must leave ack low
   property p_no_stray_ack;
      @(posedge clk) disable iff (sys_rst)
      !((reg_wr || reg_rd) && hit) |=> !reg_ack;
   endproperty
   a_no_stray_ack: assert property (p_no_stray_ack)
      else $error("ack without a mapped access");

   // unmapped reads return zero rather than stale data
   property p_stray_read_zero;
      @(posedge clk) disable iff (sys_rst)
      (reg_rd && !hit) |=> (reg_rdata == 8'h00);
   endproperty
   a_stray_read_zero: assert property (p_stray_read_zero)
      else $error("unmapped read not zero");

   // a mapped write lands in both nibbles on the taking edge
   property p_write_lands;
      @(posedge clk) disable iff (sys_rst)
      (reg_wr && hit) |=>
         (b_r.dir == $past(reg_wdata[7:4]) &&
          b_r.level == $past(reg_wdata[3:0]));
   endproperty
   a_write_lands: assert property (p_write_lands)
      else $error("write did not land");

   // input read seen from the pad: two synchroniser flops plus the read
   // edge; a reset inside that window empties the flops, so skip it
   property p_read_pin;
      @(posedge clk) disable iff (sys_rst)
      (reg_rd && hit && !b_r.dir[2] && !$past(sys_rst) &&
       !$past(sys_rst, 2)) |=> (reg_rdata[2] == $past(pin_in[2], 3));
   endproperty
   a_read_pin: assert property (p_read_pin)
      else $error("input read not pad level");

   // output read shows the stored bit, which is what the pad drives
   property p_read_output;
      @(posedge clk) disable iff (sys_rst)
      (reg_rd && hit && b_r.dir[3]) |=> (reg_rdata[3] == pin_out[3]);
   endproperty
   a_read_output: assert property (p_read_output)
      else $error("output read differs from pad drive");

   // one driver enable per pin, each one edge behind its direction bit
   for (genvar g = 0; g < WIDTH; g++) begin : g_pin_chk
      property p_oe_follows;
         @(posedge clk) disable iff (sys_rst)
         1'b1 |=> (pin_oe[g] == $past(b_r.dir[g]));
      endproperty
      a_oe_follows: assert property (p_oe_follows)
         else $error("driver enable does not follow direction");
   end
endmodule : four_pin_gpio_bank
`default_nettype wire

// file: shared/gpio_bank_pkg.sv
// package: register offset, field layout and reset values of the gpio bank
package gpio_bank_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [14:0] CONTROL_OFFSET = 15'h4102; // bank control reg
   localparam int DIR_LSB = 4;                         // direction nibble
   localparam int LEVEL_LSB = 0;                       // data nibble
   localparam int PIN_COUNT = 4;                       // pins in the bank
   localparam logic [3:0] DIR_RESET = 4'h0;            // all inputs
   localparam logic [3:0] LEVEL_RESET = 4'h0;          // data cleared
   localparam int SYNC_STAGES = 2;                     // pin synchroniser
endpackage : gpio_bank_pkg

// file: shared/gpio_pin_if.sv
// interface: pin-side signals between bank register and pin stage
`timescale 1ns/1ps
`default_nettype none
interface gpio_pin_if #(parameter int WIDTH = 4);
   logic [WIDTH-1:0] dir;     // 1 = output
   logic [WIDTH-1:0] level;   // stored data bits
   logic [WIDTH-1:0] sampled; // synchronised pin levels
   modport bank (output dir, output level, input sampled);
   modport stage (input dir, input level, output sampled);
endinterface : gpio_pin_if
`default_nettype wire

// file: src/gpio_pin_stage.sv
// module: pin synchronisers and pin drivers for the gpio bank
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_stage
   import gpio_bank_pkg::*;
#(
   parameter int WIDTH = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link to bank register
   gpio_pin_if.stage pins,
   // pads
   input wire logic [WIDTH-1:0] pad_in,
   output logic [WIDTH-1:0] pad_out,
   output logic [WIDTH-1:0] pad_oe
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [WIDTH-1:0] meta;  // first sync stage, read by stage two only
      logic [WIDTH-1:0] sync;  // second sync stage
      logic [WIDTH-1:0] out;   // driven pin value
      logic [WIDTH-1:0] oe;    // driver enable
   } stage_type;

   stage_type st_r;  // registered state
   stage_type st_nxt; // next state

   // next-state logic, one slice per pin
   always_comb begin
      st_nxt = st_r;
      st_nxt.meta = pad_in;
      st_nxt.sync = st_r.meta;
      for (int i = 0; i < WIDTH; i++) begin
         st_nxt.oe[i] = pins.dir[i];
         // data bit reaches pad only while output; stored value drives
         // at once when direction flips
         st_nxt.out[i] = pins.level[i];
      end
   end

   // registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs from flip-flops
   assign pad_out = st_r.out;
   assign pad_oe = st_r.oe;
   assign pins.sampled = st_r.sync;
endmodule : gpio_pin_stage
`default_nettype wire

// file: test/gpio_pad_model.sv
// pad model: external circuits that sit on the four gpio pins
`timescale 1ns/1ps
`default_nettype none
module gpio_pad_model (
   // from the bank's pad drivers
   input wire logic [3:0] pad_out,
   input wire logic [3:0] pad_oe,
   // level the outside circuit would set on an undriven pin
   input wire logic [3:0] ext_level,
   // resolved pad level back to the bank
   output logic [3:0] pad_level
);
   // a driven pin shows the device's value, else the outside level
   assign pad_level = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule : gpio_pad_model
`default_nettype wire

// file: test/tb_top.sv
// testbench: register accesses and pin checks for the gpio bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import gpio_bank_pkg::*;
   logic clk, sys_rst, reg_wr, reg_rd, reg_ack, ack_seen;
   logic [14:0] reg_addr; // register address
   logic [7:0] reg_wdata, reg_rdata, rd_seen;
   logic [3:0] pin_in, pin_out, pin_oe, ext_level;
   int fails = 0, total_checks = 0, cycles = 0;
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   four_pin_gpio_bank i_dut (.clk(clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
   gpio_pad_model i_pads (.pad_out(pin_out), .pad_oe(pin_oe),
      .ext_level(ext_level), .pad_level(pin_in));
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // one strobe cycle, answer sampled just after the taking edge
   task automatic acc(input logic w, input logic [14:0] a,
                      input logic [7:0] d);
      @(posedge clk);
      reg_wr <= w;
      reg_rd <= ~w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1 ack_seen = reg_ack;
      rd_seen = reg_rdata;
   endtask : acc
   // pads lag the write, and reads lag the pads through the synchroniser
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   // hang guard, far above the 53 cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         test_done();
      end
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = CONTROL_OFFSET;
      reg_wdata = 8'h00;
      ext_level = 4'hA;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      // reset emptied the pin synchroniser; let it refill first
      repeat (2) @(posedge clk);
      acc(1'b0, CONTROL_OFFSET, 8'h00);
      chk("reset read", {DIR_RESET, 4'hA}, rd_seen);
      chk("reset oe", 8'h00, {4'h0, pin_oe});
      $display("test reset done");
      acc(1'b1, CONTROL_OFFSET, 8'h05);
      chk("write ack", 8'h01, {7'h0, ack_seen});
      settle();
      chk("input pins", 8'h00, {4'h0, pin_oe});
      chk("input pads", 8'h0A, {4'h0, pin_in});
      acc(1'b0, CONTROL_OFFSET, 8'h00);
      chk("input read", 8'h0A, rd_seen);
      $display("test inputs done");
      acc(1'b1, CONTROL_OFFSET, 8'hF5);
      settle();
      chk("outputs", 8'hF5, {pin_oe, pin_out});
      acc(1'b0, CONTROL_OFFSET, 8'h00);
      chk("output read", 8'hF5, rd_seen);
      $display("test outputs done");
      @(posedge clk);
      ext_level <= 4'h6;
      acc(1'b1, CONTROL_OFFSET, 8'h9C);
      settle();
      chk("mixed pins", 8'h98, {pin_oe, pin_out & pin_oe});
      acc(1'b0, CONTROL_OFFSET, 8'h00);
      chk("mixed read", 8'h9E, rd_seen);
      $display("test mixed done");
      acc(1'b1, 15'h0102, 8'h00);
      chk("unmapped write ack", 8'h00, {7'h0, ack_seen});
      acc(1'b0, 15'h0102, 8'h00);
      chk("unmapped read", 8'h00, {7'h0, ack_seen} | rd_seen);
      acc(1'b0, CONTROL_OFFSET, 8'h00);
      chk("after unmapped", 8'h9E, rd_seen);
      $display("test unmapped done");
      // two writes on consecutive edges, the later must win
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_wdata <= 8'hF0;
      @(posedge clk);
      reg_wdata <= 8'hFF;
      @(posedge clk);
      reg_wr <= 1'b0;
      settle();
      chk("back to back", 8'hFF, {pin_oe, pin_out});
      $display("test back to back done");
      // reset in mid-run: pins back to inputs, both nibbles cleared
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      acc(1'b0, CONTROL_OFFSET, 8'h00);
      chk("mid reset read", {DIR_RESET, 4'h6}, rd_seen);
      chk("mid reset pads", 8'h00, {pin_oe, pin_out});
      $display("test mid reset done");
      test_done();
   end
endmodule : tb_top
`default_nettype wire
